// ---- hw/fsm_defines.svh ----
`ifndef FSM_DEFINES_SVH
`define FSM_DEFINES_SVH
// register offsets (byte addresses)
`define FSM_REG_CTRL 8'h00
`define FSM_REG_IVL 8'h04
`define FSM_REG_PMAX 8'h08
`define FSM_REG_RANGE 8'h0C
`define FSM_REG_STATUS 8'h10
`define FSM_REG_DIRT 8'h14
`define FSM_REG_TIME 8'h18
// ctrl fields
`define FSM_CTRL_RUN 0
`define FSM_CTRL_LOG 1
// status fields
`define FSM_ST_ERR 0
`define FSM_ST_WARN 8
`define FSM_ST_RELAY 11
`define FSM_ST_WARM 12
// reset values
`define FSM_IVL_RST 14'h003C
`define FSM_PMAX_RST 16'h0FA0
`define FSM_RANGE_RST 16'hFFFF
// limits
`define FSM_IVL_MIN 14'h0001
`define FSM_IVL_MAX 14'h270F
`define FSM_DIRT_WARN 7'h32
`define FSM_DIRT_ERR 7'h3C
`define FSM_LOWP_MBAR 16'h00C8
// timing
`define FSM_CLK_NS 20
`define FSM_SEC_NS 1000000000
`define FSM_SEC_CYC (`FSM_SEC_NS / `FSM_CLK_NS)
`endif

// ---- hw/fsm_pkg.sv ----
package fsm_pkg;
  typedef enum logic [2:0] {
    FSM_LAMP_OK, FSM_LAMP_WEAK, FSM_LAMP_LOW, FSM_LAMP_OFF, FSM_LAMP_HIGH
  } fsm_lamp_type;
  typedef enum logic [3:0] {
    FSM_MSG_NONE, FSM_MSG_LAMP_WEAK, FSM_MSG_LAMP_LOW, FSM_MSG_LAMP_OFF, FSM_MSG_LAMP_HIGH,
    FSM_MSG_DIRT_WARN, FSM_MSG_DIRT_ERR, FSM_MSG_OVERPRESS, FSM_MSG_OVERRANGE,
    FSM_MSG_LOW_PRESS, FSM_MSG_NVM, FSM_MSG_STORAGE
  } fsm_msg_type;
  typedef enum logic [1:0] {
    FSM_REC_ERR_ON, FSM_REC_ERR_OFF, FSM_REC_EVENT
  } fsm_kind_type;
  // error bit order: lamp low, lamp off, lamp high, dirt, overpress, overrange, low press, nvm
  typedef struct packed {
    fsm_lamp_type lamp;
    logic nvm_fault;
    logic [15:0] pressure;
    logic [15:0] conc;
    logic [15:0] temperature;
  } fsm_meas_type;
  typedef struct packed {
    fsm_kind_type kind;
    logic [2:0] code;
    logic [15:0] data;
    logic [31:0] stamp;
  } fsm_rec_type;
  typedef struct packed {
    logic err_relay_ok;
    logic lamp_contact_ok;
    logic dirt_contact_ok;
    logic out_saturate;
    fsm_msg_type msg;
    logic msg_alternate;
    logic beep;
  } fsm_out_type;
endpackage : fsm_pkg

// ---- hw/fsm_top.sv ----
// What this block does
// [RULE1] weak lamp: lamp contact open, relay normal
// [RULE2] lamp low error: relay error, contact open
// [RULE3] lamp off: saturate outputs, steady message
// [RULE4] lamp too bright raises relay error
// [RULE5] every zeroing updates stored dirtiness
// [RULE6] dirt above 50%: soiled contact, warning
// [RULE7] dirt warning survives power, cleared by zeroing
// [RULE8] dirt above 60%: relay error, error message
// [RULE9] pressure above maximum: overpressure error
// [RULE10] overrange: relay error, saturate, alternate message
// [RULE11] pressure below 0.2 bar: low-pressure error
// [RULE12] memory fault raises relay error
// [RULE13] log write failure: warning only
// [RULE14] records appended in order, 1 s stamps
// [RULE15] error begin and end each logged
// [RULE16] power, zeroing and alarm events logged
// [RULE17] concentration sampled every 1 to 9999 s
// [RULE18] records appended with no capacity limit
// [RULE19] warm-up holds relay in error
// [RULE20] beep on faults, back button silences
// [RULE21] relay error while any error active
// [RULE22] contacts open while warning or error active; lamp contact opens on weak/low/off lamp, dirt contact on dirt warning/error
//
// The placing of the registers and the plain strobed port were decided locally.
`include "fsm_defines.svh"
module fsm_top #(
  parameter int unsigned SEC_CYC = `FSM_SEC_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // measurements
  input wire fsm_pkg::fsm_meas_type meas,
  input wire logic zero_done,
  input wire logic [6:0] zero_dirt,
  input wire logic [6:0] saved_dirt,
  input wire logic log_wr_fail,
  input wire logic power_fail,
  input wire logic alarm_hi,
  input wire logic alarm_lo,
  input wire logic [15:0] alarm_hi_limit,
  input wire logic [15:0] alarm_lo_limit,
  // front panel
  input wire logic back_btn_pin,
  input wire logic menu_top,
  // outputs
  output fsm_pkg::fsm_out_type outs,
  output logic [6:0] dirt_save,
  output fsm_pkg::fsm_rec_type rec,
  output logic rec_valid
);
  import fsm_pkg::*;

  localparam int unsigned NPEND = 24;
  localparam logic [25:0] SEC_LAST = 26'(SEC_CYC - 1);

  typedef struct packed {
    logic back_s1;
    logic back_s2;
    logic back_prev;
    logic run;
    logic log_en;
    logic [13:0] ivl;
    logic [15:0] pmax;
    logic [15:0] range_max;
    logic [25:0] div;
    logic [31:0] secs;
    logic [13:0] ivl_cnt;
    logic [6:0] dirt;
    logic dirt_loaded;
    logic storage;
    logic [7:0] err_prev;
    logic [NPEND-1:0] pend;
    logic hi_prev;
    logic lo_prev;
    logic [10:0] fault_prev;
    logic beep;
    logic alt;
    fsm_out_type outs;
    fsm_rec_type rec;
    logic rec_valid;
    logic [31:0] rdata;
  } fsm_state_type;

  fsm_state_type st, next_st;

  // lowest set pending bit wins, even over higher bits that were raised in an earlier cycle
  function automatic logic [4:0] fsm_first(input logic [NPEND-1:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = NPEND - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : fsm_first

  logic tick;
  logic [7:0] err;
  logic [2:0] warn;
  logic any_err;
  logic [4:0] sel;

  always_comb begin
    tick = (st.div == SEC_LAST);
    err[0] = (meas.lamp == FSM_LAMP_LOW); // see [RULE2]
    err[1] = (meas.lamp == FSM_LAMP_OFF); // see [RULE3]
    err[2] = (meas.lamp == FSM_LAMP_HIGH); // see [RULE4]
    err[3] = (st.dirt > `FSM_DIRT_ERR); // see [RULE8]
    err[4] = (meas.pressure > st.pmax); // see [RULE9]
    err[5] = (meas.conc > st.range_max); // see [RULE10]
    err[6] = (meas.pressure < `FSM_LOWP_MBAR); // see [RULE11]
    err[7] = meas.nvm_fault; // see [RULE12]
    warn[0] = (meas.lamp == FSM_LAMP_WEAK); // see [RULE1]
    warn[1] = (st.dirt > `FSM_DIRT_WARN); // see [RULE6]
    warn[2] = st.storage; // see [RULE13]
    any_err = |err;
    sel = fsm_first(st.pend);
  end

  always_comb begin
    next_st = st;
    next_st.back_s1 = back_btn_pin;
    next_st.back_s2 = st.back_s1;
    next_st.back_prev = st.back_s2;
    next_st.rec_valid = 1'b0;
    next_st.rdata = 32'h0000_0000;
    // one second time base, stamps have 1 s resolution
    next_st.div = tick ? 26'h000_0000 : st.div + 26'h000_0001;
    if (tick) begin
      next_st.secs = st.secs + 32'h0000_0001; // see [RULE14]
      next_st.alt = ~st.alt;
    end
    // restore the saved dirtiness once after reset so the warning reappears
    if (!st.dirt_loaded) begin
      next_st.dirt = saved_dirt; // see [RULE7]
      next_st.dirt_loaded = 1'b1;
    end
    if (zero_done) begin
      next_st.dirt = zero_dirt; // see [RULE5] see [RULE7]
      next_st.pend[16 + 2] = 1'b1; // see [RULE16]
    end
    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        `FSM_REG_CTRL: begin
          next_st.run = reg_wdata[`FSM_CTRL_RUN];
          next_st.log_en = reg_wdata[`FSM_CTRL_LOG];
          next_st.ivl_cnt = 14'h0000;
        end
        `FSM_REG_IVL: begin
          if (reg_wdata[13:0] < `FSM_IVL_MIN) begin
            next_st.ivl = `FSM_IVL_MIN; // see [RULE17]
          end else if (reg_wdata[13:0] > `FSM_IVL_MAX) begin
            next_st.ivl = `FSM_IVL_MAX; // see [RULE17]
          end else begin
            next_st.ivl = reg_wdata[13:0];
          end
        end
        `FSM_REG_PMAX: next_st.pmax = reg_wdata[15:0];
        `FSM_REG_RANGE: next_st.range_max = reg_wdata[15:0];
        `FSM_REG_STATUS: begin
          if (reg_wdata[`FSM_ST_WARN + 2]) begin
            next_st.storage = 1'b0;
          end
        end
        `FSM_REG_TIME: next_st.secs = reg_wdata;
        default: ;
      endcase
    end
    // a failure in the clear cycle still sets the warning
    if (log_wr_fail) begin
      next_st.storage = 1'b1; // see [RULE13]
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `FSM_REG_CTRL: next_st.rdata = {30'h0000_0000, st.log_en, st.run};
        `FSM_REG_IVL: next_st.rdata = {18'h0_0000, st.ivl};
        `FSM_REG_PMAX: next_st.rdata = {16'h0000, st.pmax};
        `FSM_REG_RANGE: next_st.rdata = {16'h0000, st.range_max};
        `FSM_REG_STATUS: begin
          next_st.rdata = {19'h0_0000, ~st.run, ~st.outs.err_relay_ok, warn, err};
        end
        `FSM_REG_DIRT: next_st.rdata = {25'h000_0000, st.dirt};
        `FSM_REG_TIME: next_st.rdata = st.secs;
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
    // log sources: error edges and events
    next_st.err_prev = err;
    next_st.pend[7:0] = next_st.pend[7:0] | (err & ~st.err_prev); // see [RULE15]
    next_st.pend[15:8] = next_st.pend[15:8] | (~err & st.err_prev); // see [RULE15]
    next_st.hi_prev = alarm_hi;
    next_st.lo_prev = alarm_lo;
    if (power_fail) begin
      next_st.pend[16 + 1] = 1'b1; // see [RULE16]
    end
    if (alarm_hi && !st.hi_prev) begin
      next_st.pend[16 + 3] = 1'b1; // see [RULE16]
    end
    if (!alarm_hi && st.hi_prev) begin
      next_st.pend[16 + 4] = 1'b1; // see [RULE16]
    end
    if (alarm_lo && !st.lo_prev) begin
      next_st.pend[16 + 5] = 1'b1; // see [RULE16]
    end
    if (!alarm_lo && st.lo_prev) begin
      next_st.pend[16 + 6] = 1'b1; // see [RULE16]
    end
    if (st.log_en && tick) begin
      if (st.ivl_cnt + 14'h0001 >= st.ivl) begin
        next_st.ivl_cnt = 14'h0000;
        next_st.pend[16 + 7] = 1'b1; // see [RULE17]
      end else begin
        next_st.ivl_cnt = st.ivl_cnt + 14'h0001;
      end
    end
    // drain one record per cycle; the stream has no end, storage grows outside
    if (|st.pend) begin
      next_st.pend[sel] = 1'b0; // see [RULE18]
      next_st.rec_valid = 1'b1; // see [RULE14]
      next_st.rec.stamp = st.secs; // see [RULE14]
      next_st.rec.code = sel[2:0];
      next_st.rec.data = 16'h0000;
      if (sel < 5'h8) begin
        next_st.rec.kind = FSM_REC_ERR_ON;
      end else if (sel < 5'h10) begin
        next_st.rec.kind = FSM_REC_ERR_OFF;
      end else begin
        next_st.rec.kind = FSM_REC_EVENT;
        unique case (sel[2:0])
          3'h0: next_st.rec.data = meas.pressure;
          3'h1: next_st.rec.data = meas.temperature;
          3'h2: next_st.rec.data = {9'h000, st.dirt};
          3'h3, 3'h4: next_st.rec.data = alarm_hi_limit;
          3'h5, 3'h6: next_st.rec.data = alarm_lo_limit;
          3'h7: next_st.rec.data = meas.conc;
        endcase
      end
    end
    // relay and contacts
    next_st.outs.err_relay_ok = st.run && !any_err; // see [RULE19] see [RULE21]
    next_st.outs.lamp_contact_ok = !(warn[0] | err[0] | err[1]); // see [RULE22]
    next_st.outs.dirt_contact_ok = !(warn[1] | err[3]); // see [RULE22]
    next_st.outs.out_saturate = err[1] | err[5]; // see [RULE3] see [RULE10]
    // display: the most severe condition wins; only lamp off stays steady
    next_st.outs.msg_alternate = 1'b1;
    if (err[1]) begin
      next_st.outs.msg = FSM_MSG_LAMP_OFF; // see [RULE3]
      next_st.outs.msg_alternate = 1'b0;
    end else if (err[7]) begin
      next_st.outs.msg = FSM_MSG_NVM;
    end else if (err[2]) begin
      next_st.outs.msg = FSM_MSG_LAMP_HIGH;
    end else if (err[0]) begin
      next_st.outs.msg = FSM_MSG_LAMP_LOW;
    end else if (err[4]) begin
      next_st.outs.msg = FSM_MSG_OVERPRESS;
    end else if (err[6]) begin
      next_st.outs.msg = FSM_MSG_LOW_PRESS;
    end else if (err[5]) begin
      next_st.outs.msg = FSM_MSG_OVERRANGE; // see [RULE10]
    end else if (err[3]) begin
      next_st.outs.msg = FSM_MSG_DIRT_ERR; // see [RULE8]
    end else if (warn[0]) begin
      next_st.outs.msg = FSM_MSG_LAMP_WEAK; // see [RULE1]
    end else if (warn[1]) begin
      next_st.outs.msg = FSM_MSG_DIRT_WARN; // see [RULE6]
    end else if (warn[2]) begin
      next_st.outs.msg = FSM_MSG_STORAGE;
    end else begin
      next_st.outs.msg = FSM_MSG_NONE;
      next_st.outs.msg_alternate = 1'b0;
    end
    // beeper re-arms on any newly raised fault, back at top menu silences it
    next_st.fault_prev = {warn, err};
    if (|({warn, err} & ~st.fault_prev)) begin
      next_st.beep = 1'b1; // see [RULE20]
    end else if (!(|{warn, err})) begin
      next_st.beep = 1'b0;
    end else if (st.back_s2 && !st.back_prev && menu_top) begin
      next_st.beep = 1'b0; // see [RULE20]
    end
    next_st.outs.beep = st.beep;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
      st.ivl <= `FSM_IVL_RST;
      st.pmax <= `FSM_PMAX_RST;
      st.range_max <= `FSM_RANGE_RST;
      st.pend <= 24'h01_0000;
      st.outs.lamp_contact_ok <= 1'b1;
      st.outs.dirt_contact_ok <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    outs = st.outs;
    outs.msg_alternate = st.outs.msg_alternate & st.alt;
    dirt_save = st.dirt;
    rec = st.rec;
    rec_valid = st.rec_valid;
    reg_rdata = st.rdata;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_zero;
    zero_done && zero_dirt > `FSM_DIRT_ERR;
  endsequence
  sequence s_dirt_err_out;
    !outs.dirt_contact_ok && !outs.err_relay_ok;
  endsequence

  AST_WEAK_CONTACT: assert property (meas.lamp == FSM_LAMP_WEAK && !(|err) // see [RULE1]
    |=> !outs.lamp_contact_ok) else $error("weak lamp left contact closed");
  AST_LAMP_LOW: assert property (meas.lamp == FSM_LAMP_LOW // see [RULE2]
    |=> !outs.err_relay_ok && !outs.lamp_contact_ok) else $error("lamp low outputs");
  AST_LAMP_OFF: assert property (meas.lamp == FSM_LAMP_OFF |=> outs.out_saturate // see [RULE3]
    && outs.msg == FSM_MSG_LAMP_OFF && !outs.msg_alternate) else $error("lamp off outputs");
  AST_DIRT_ERR: assert property (s_zero ##1 st.dirt > `FSM_DIRT_ERR // see [RULE8]
    |=> s_dirt_err_out) else $error("dirt error outputs");
  AST_LOW_PRESS: assert property (meas.pressure < `FSM_LOWP_MBAR // see [RULE11]
    |=> !outs.err_relay_ok) else $error("low pressure not flagged");
  // the relay follows the run bit of the cycle before, a control write may fall in between
  AST_STORAGE: assert property (log_wr_fail && !(|err) && !warn[0] && !warn[1] // see [RULE13]
    ##1 !(|err) && !warn[0] |=> outs.err_relay_ok == $past(st.run) && outs.lamp_contact_ok
    && !outs.out_saturate) else $error("storage warning touched outputs");
  // a lower error rising in the same cycle is drained first
  AST_ERR_LOG: assert property ($rose(err[7]) && !(|st.pend) // see [RULE15]
    && ((err[6:0] & ~st.err_prev[6:0]) == 7'h00)
    |=> ##1 rec_valid && rec.kind == FSM_REC_ERR_ON && rec.code == 3'h7)
    else $error("error begin not logged");
  AST_WARMUP: assert property (!st.run |=> !outs.err_relay_ok) // see [RULE19]
    else $error("relay normal during warm-up");
  // software may set the clock back, so the stamp is tied to its own cycle
  AST_STAMP: assert property (rec_valid |-> rec.stamp == $past(st.secs)) // see [RULE14]
    else $error("record stamp not the second of its drain");
endmodule : fsm_top

// ---- bench/fsm_plant_model.sv ----
module fsm_plant_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // record stream from the block
  input wire fsm_pkg::fsm_rec_type rec,
  input wire logic rec_valid,
  // summary seen by the plant
  output fsm_pkg::fsm_rec_type last_rec,
  output logic [7:0] on_cnt,
  output logic [7:0] off_cnt,
  output logic order_bad
);
  timeunit 1ns;
  timeprecision 1ns;
  import fsm_pkg::*;
  // accepts a record every cycle, the stream has no back-pressure
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      last_rec <= '0;
      on_cnt <= 8'h00;
      off_cnt <= 8'h00;
      order_bad <= 1'b0;
    end else if (rec_valid) begin
      last_rec <= rec;
      if (rec.stamp < last_rec.stamp) begin
        order_bad <= 1'b1;
      end
      if (rec.kind == FSM_REC_ERR_ON) begin
        on_cnt <= on_cnt + 8'h01;
      end
      if (rec.kind == FSM_REC_ERR_OFF) begin
        off_cnt <= off_cnt + 8'h01;
      end
    end
  end
endmodule : fsm_plant_model

// ---- bench/fault_status_manager_tb_top.sv ----
`include "fsm_defines.svh"
module fault_status_manager_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fsm_pkg::*;
  // one second shortened to ten cycles keeps the log tests brief
  localparam int unsigned SEC = 10;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  fsm_meas_type meas = '{FSM_LAMP_OK, 1'b0, 16'h03E8, 16'h0000, 16'h0019};
  logic zero_done = 1'b0;
  logic [6:0] zero_dirt = 7'h00;
  logic [6:0] saved_dirt = 7'h00;
  logic log_wr_fail = 1'b0;
  logic power_fail = 1'b0;
  logic alarm_hi = 1'b0;
  logic alarm_lo = 1'b0;
  logic back_btn_pin = 1'b0;
  logic menu_top = 1'b0;
  fsm_out_type outs;
  logic [6:0] dirt_save;
  fsm_rec_type rec;
  logic rec_valid;
  fsm_rec_type last_rec;
  logic [7:0] on_cnt;
  logic [7:0] off_cnt;
  logic order_bad;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  fsm_top #(.SEC_CYC(SEC)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .meas(meas), .zero_done(zero_done), .zero_dirt(zero_dirt), .saved_dirt(saved_dirt),
    .log_wr_fail(log_wr_fail), .power_fail(power_fail), .alarm_hi(alarm_hi),
    .alarm_lo(alarm_lo), .alarm_hi_limit(16'h0123), .alarm_lo_limit(16'h0045),
    .back_btn_pin(back_btn_pin), .menu_top(menu_top), .outs(outs), .dirt_save(dirt_save),
    .rec(rec), .rec_valid(rec_valid));
  fsm_plant_model u_plant (.sys_clk(sys_clk), .rst_n(rst_n), .rec(rec), .rec_valid(rec_valid),
    .last_rec(last_rec), .on_cnt(on_cnt), .off_cnt(off_cnt), .order_bad(order_bad));
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic results();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  // a hang is cut short well beyond the few hundred cycles the tests need
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      results();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : reg_read
  task automatic expect_rec(input fsm_kind_type k, input logic [2:0] c, input logic [15:0] d,
      input int lim);
    int n;
    n = 0;
    #1;
    while (rec_valid !== 1'b1 && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check({31'h0, rec_valid}, 32'h1);
    check({27'h0, rec.kind, rec.code}, {27'h0, k, c});
    if (k == FSM_REC_EVENT) begin
      check({16'h0, rec.data}, {16'h0, d});
    end
  endtask : expect_rec
  task automatic chk_out(input logic r, input fsm_msg_type m);
    check({31'h0, outs.err_relay_ok}, {31'h0, r});
    check({28'h0, outs.msg}, {28'h0, m});
  endtask : chk_out
  task automatic do_reset();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask : do_reset
  task automatic t_warmup();
    expect_rec(FSM_REC_EVENT, 3'h0, 16'h03E8, 10);
    tick(2);
    check({31'h0, outs.err_relay_ok}, 32'h0);
    reg_read(`FSM_REG_STATUS, 32'h0000_1800);
    reg_read(`FSM_REG_IVL, 32'h0000_003C);
    reg_read(`FSM_REG_PMAX, 32'h0000_0FA0);
    reg_read(`FSM_REG_RANGE, 32'h0000_FFFF);
    reg_read(8'h1C, 32'h0);
    reg_write(`FSM_REG_CTRL, 32'h1);
    tick(3);
    chk_out(1'b1, FSM_MSG_NONE);
    $display("test warmup done");
  endtask : t_warmup
  task automatic t_lamp();
    fsm_lamp_type lt [4] = '{FSM_LAMP_WEAK, FSM_LAMP_LOW, FSM_LAMP_OFF, FSM_LAMP_HIGH};
    fsm_msg_type mt [4] = '{FSM_MSG_LAMP_WEAK, FSM_MSG_LAMP_LOW, FSM_MSG_LAMP_OFF,
      FSM_MSG_LAMP_HIGH};
    logic [7:0] on0;
    logic [7:0] off0;
    logic alt_seen;
    on0 = on_cnt;
    off0 = off_cnt;
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      meas.lamp <= lt[i];
      tick(3);
      chk_out(i == 0, mt[i]);
      if (i < 3) begin
        check({31'h0, outs.lamp_contact_ok}, 32'h0);
        check({31'h0, outs.out_saturate}, {31'h0, i == 2});
      end
      // one second later the warning must have swapped phase with the results
      if (i == 0) begin
        alt_seen = outs.msg_alternate;
        tick(SEC);
        check({31'h0, outs.msg_alternate ^ alt_seen}, 32'h1);
      end
      if (i == 2) begin
        check({31'h0, outs.msg_alternate}, 32'h0);
      end
    end
    @(posedge sys_clk);
    meas.lamp <= FSM_LAMP_OK;
    tick(4);
    check({31'h0, outs.lamp_contact_ok}, 32'h1);
    chk_out(1'b1, FSM_MSG_NONE);
    check({24'h0, on_cnt - on0}, 32'h3);
    check({24'h0, off_cnt - off0}, 32'h3);
    $display("test lamp done");
  endtask : t_lamp
  task automatic t_dirt();
    logic [6:0] dv [5] = '{7'h33, 7'h32, 7'h3D, 7'h3C, 7'h0A};
    logic [4:0] ct = 5'b10010;
    logic [4:0] rl = 5'b11011;
    fsm_msg_type mt [5] = '{FSM_MSG_DIRT_WARN, FSM_MSG_NONE, FSM_MSG_DIRT_ERR,
      FSM_MSG_DIRT_WARN, FSM_MSG_NONE};
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      zero_dirt <= dv[i];
      zero_done <= 1'b1;
      @(posedge sys_clk);
      zero_done <= 1'b0;
      if (i == 0) begin
        expect_rec(FSM_REC_EVENT, 3'h2, 16'h0033, 10);
      end
      tick(4);
      check({25'h0, dirt_save}, {25'h0, dv[i]});
      check({31'h0, outs.dirt_contact_ok}, {31'h0, ct[i]});
      chk_out(rl[i], mt[i]);
    end
    reg_read(`FSM_REG_DIRT, 32'h0000_000A);
    $display("test dirt done");
  endtask : t_dirt
  task automatic t_press();
    logic [15:0] pv [4] = '{16'h0FA1, 16'h0FA0, 16'h00C7, 16'h00C8};
    fsm_msg_type mt [4] = '{FSM_MSG_OVERPRESS, FSM_MSG_NONE, FSM_MSG_LOW_PRESS, FSM_MSG_NONE};
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      meas.pressure <= pv[i];
      tick(3);
      chk_out(i[0], mt[i]);
    end
    reg_write(`FSM_REG_RANGE, 32'h0000_1000);
    meas.conc <= 16'h1001;
    tick(3);
    chk_out(1'b0, FSM_MSG_OVERRANGE);
    check({31'h0, outs.out_saturate}, 32'h1);
    $display("test press done");
  endtask : t_press
  task automatic t_nvm();
    @(posedge sys_clk);
    meas.conc <= 16'h0077;
    meas.nvm_fault <= 1'b1;
    expect_rec(FSM_REC_ERR_ON, 3'h7, 16'h0, 10);
    tick(3);
    chk_out(1'b0, FSM_MSG_NVM);
    check({31'h0, outs.beep}, 32'h1);
    @(posedge sys_clk);
    menu_top <= 1'b1;
    back_btn_pin <= 1'b1;
    repeat (2) @(posedge sys_clk);
    back_btn_pin <= 1'b0;
    tick(6);
    check({31'h0, outs.beep}, 32'h0);
    @(posedge sys_clk);
    meas.nvm_fault <= 1'b0;
    expect_rec(FSM_REC_ERR_OFF, 3'h7, 16'h0, 10);
    $display("test nvm done");
  endtask : t_nvm
  task automatic t_store();
    @(posedge sys_clk);
    log_wr_fail <= 1'b1;
    @(posedge sys_clk);
    log_wr_fail <= 1'b0;
    tick(3);
    chk_out(1'b1, FSM_MSG_STORAGE);
    check({29'h0, outs.lamp_contact_ok, outs.dirt_contact_ok, outs.out_saturate},
      32'h6);
    reg_read(`FSM_REG_STATUS, 32'h0000_0400);
    reg_write(`FSM_REG_STATUS, 32'h0000_0400);
    reg_read(`FSM_REG_STATUS, 32'h0);
    $display("test store done");
  endtask : t_store
  task automatic alarm(input logic hi, input logic lo, input logic [2:0] c,
      input logic [15:0] lim);
    @(posedge sys_clk);
    alarm_hi <= hi;
    alarm_lo <= lo;
    expect_rec(FSM_REC_EVENT, c, lim, 10);
  endtask : alarm
  task automatic t_events();
    logic [31:0] s0;
    @(posedge sys_clk);
    power_fail <= 1'b1;
    @(posedge sys_clk);
    power_fail <= 1'b0;
    expect_rec(FSM_REC_EVENT, 3'h1, 16'h0019, 10);
    alarm(1'b1, 1'b0, 3'h3, 16'h0123);
    alarm(1'b0, 1'b0, 3'h4, 16'h0123);
    alarm(1'b0, 1'b1, 3'h5, 16'h0045);
    alarm(1'b0, 1'b0, 3'h6, 16'h0045);
    reg_write(`FSM_REG_IVL, 32'h0);
    reg_read(`FSM_REG_IVL, 32'h1);
    reg_write(`FSM_REG_IVL, 32'h2710);
    reg_read(`FSM_REG_IVL, 32'h270F);
    reg_write(`FSM_REG_IVL, 32'h2);
    reg_write(`FSM_REG_CTRL, 32'h3);
    expect_rec(FSM_REC_EVENT, 3'h7, 16'h0077, 60);
    s0 = rec.stamp;
    tick(1);
    expect_rec(FSM_REC_EVENT, 3'h7, 16'h0077, 60);
    check(rec.stamp - s0, 32'h2);
    check({31'h0, order_bad}, 32'h0);
    reg_write(`FSM_REG_CTRL, 32'h1);
    $display("test events done");
  endtask : t_events
  task automatic t_persist();
    @(posedge sys_clk);
    saved_dirt <= 7'h37;
    do_reset();
    // the power-on record carries the pressure last applied, 200 mbar
    expect_rec(FSM_REC_EVENT, 3'h0, 16'h00C8, 10);
    tick(2);
    check({25'h0, dirt_save}, 32'h37);
    check({31'h0, outs.dirt_contact_ok}, 32'h0);
    check({31'h0, outs.err_relay_ok}, 32'h0);
    $display("test persist done");
  endtask : t_persist
  initial begin
    do_reset();
    t_warmup();
    t_lamp();
    t_dirt();
    t_press();
    t_nvm();
    t_store();
    t_events();
    t_persist();
    results();
  end
endmodule : fault_status_manager_tb_top
